//--- shared/css_cfg.svh
// Purpose: constants for the channel status setup block
// Assumes: status slot n sits at bit n of a 32-bit group word
// Notes:   printed codes are written leftmost first; leftmost lands on the lowest slot
//
// Summary of operation
// - two-channel mode inserts channel number by word clock, swapped by polarity select
// - four-channel mode alone forces all channel number bits to zero
// - parallel mode encodes rate slots from the two rate select pins
// - rate select a high with b low means serial mode, else parallel
// - parallel mode encodes accuracy slots from the two accuracy select pins
// - both accuracy selects high disables and holds both digital outputs low
// - serial mode uses category selects as data, clock and latch
// - serial mode emphasis slot is emphasis pin ORed with loaded emphasis bit
// - serial mode accuracy select b high disables outputs; host holds a high
// - serially loaded status lives in a 32-bit setting register
// - length select high loads first 32 bits, applied from next block
// - length select low loads six groups, captured at each frame32 marker fall
// - block start output is high during frames 0 to 31 of each block
// - serial data is sampled on each rising serial clock edge
// - parallel slot 2 follows copy pin, slot 3 follows emphasis pin
// - parallel slots 0, 1, 4 are zero; category from category selects and length
// - parallel slot 5 shows four channels per pin when channel mode select b is high
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH

`define CSS_SLOT_COPY      2
`define CSS_SLOT_EMPHASIS_PIN      3
`define CSS_SLOT_CHMODE    5
`define CSS_SLOT_CAT       8
`define CSS_SLOT_CHNUM     20
`define CSS_SLOT_RATE      24
`define CSS_SLOT_ACC       28

`define CSS_WORD_RESET     32'h0000_0000
`define CSS_CHNUM_FIRST    8'h08
`define CSS_CHNUM_SECOND   8'h04
`define CSS_RATE_44K1      8'h00
`define CSS_RATE_48K       8'h04
`define CSS_RATE_32K       8'h0C
`define CSS_ACC_LEVEL2     8'h00
`define CSS_ACC_LEVEL3     8'h01
`define CSS_ACC_LEVEL1     8'h02

`define CSS_CAT_GENERAL    7'h00
`define CSS_CAT_MIXER      7'h24
`define CSS_CAT_RATECONV   7'h2C
`define CSS_CAT_SAMPLER    7'h22
`define CSS_CAT_ADC_FREE   7'h30
`define CSS_CAT_ADC_PROT   7'h34
`define CSS_CAT_SYNTH      7'h50
`define CSS_CAT_MIC        7'h58

`define CSS_FRAMES_GROUP   32
`define CSS_GROUPS_BLOCK   6

`endif

//--- shared/css_pkg.sv
// Purpose: types of the channel status setup block
// Assumes: constants live in css_cfg.svh
// Notes:   no numbers here, only enumerations
package css_pkg;

  typedef enum logic {CSS_PARALLEL, CSS_SERIAL} css_mode_t;

  typedef enum logic {CSS_LOAD_192, CSS_LOAD_32} css_load_t;

endpackage

//--- core/css_channel_status_setup.sv
// Purpose: builds channel status group words, frame markers and gated digital outputs
// Assumes: frame_tick_i is a one-cycle pulse per frame from the framing logic on clk_i
// Notes:   the serial shifter runs on the serial clock pin, all else on clk_i
`timescale 1ns/1ps
`include "css_cfg.svh"

module css_channel_status_setup #(
  parameter int FRAMES_PER_GROUP = `CSS_FRAMES_GROUP,
  parameter int GROUPS_PER_BLOCK = `CSS_GROUPS_BLOCK
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        rate_select_a_i,
  input  wire logic        rate_select_b_i,
  input  wire logic        accuracy_select_a_i,
  input  wire logic        accuracy_select_b_i,
  input  wire logic        category_select_1_i,
  input  wire logic        category_select_2_i,
  input  wire logic        category_select_3_i,
  input  wire logic        length_select_i,
  input  wire logic        emphasis_pin_i,
  input  wire logic        copy_pin_i,
  input  wire logic        channel_mode_select_b_i,
  input  wire logic        clock_polarity_select_i,
  input  wire logic        word_clock_i,
  input  wire logic        frame_tick_i,
  input  wire logic        mod_data_a_i,
  input  wire logic        mod_data_b_i,
  output logic             digital_out_a_o,
  output logic             digital_out_b_o,
  output logic             block_start_o,
  output logic             frame32_marker_o,
  output logic [31:0]      status_word_o,
  output logic [2:0]       status_group_o,
  output logic             serial_mode_o,
  output logic             output_disable_o
);

  // refuse shapes the counters and group index cannot serve
  if (FRAMES_PER_GROUP < 2 || FRAMES_PER_GROUP > 256 || GROUPS_PER_BLOCK < 1 || GROUPS_PER_BLOCK > 8)
  begin : g_bad_shape
    $error("css_channel_status_setup: unsupported group or block size");
  end

  localparam int PW = 13;
  localparam int P_RA = 0;
  localparam int P_RB = 1;
  localparam int P_AA = 2;
  localparam int P_AB = 3;
  localparam int P_C1 = 4;
  localparam int P_C2 = 5;
  localparam int P_C3 = 6;
  localparam int P_LEN = 7;
  localparam int P_EMPHASIS_PIN = 8;
  localparam int P_COPY = 9;
  localparam int P_M2 = 10;
  localparam int P_LRS = 11;
  localparam int P_WCK = 12;
  localparam logic [7:0] GRP_LAST = 8'(FRAMES_PER_GROUP - 1);
  localparam logic [7:0] GRP_HALF = 8'(FRAMES_PER_GROUP / 2 - 1);
  localparam logic [2:0] BLK_LAST = 3'(GROUPS_PER_BLOCK - 1);

  // place a printed code of n bits at slot lsb, leftmost digit on the lowest slot
  function automatic logic [31:0] place(input logic [7:0] code, input int n, input int lsb);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < n; i++)
    begin
      w[lsb + i] = code[n - 1 - i];
    end
    return w;
  endfunction

  logic [PW-1:0] pins_raw;
  logic [PW-1:0] sync1_q;
  logic [PW-1:0] sync2_q;

  assign pins_raw = {word_clock_i, clock_polarity_select_i, channel_mode_select_b_i, copy_pin_i,
                     emphasis_pin_i, length_select_i, category_select_3_i, category_select_2_i,
                     category_select_1_i, accuracy_select_b_i, accuracy_select_a_i,
                     rate_select_b_i, rate_select_a_i};

  // two-stage synchronisers, one per pin; stage one feeds only stage two
  generate
    for (genvar g = 0; g < PW; g++)
    begin : g_sync
      always_ff @(posedge clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end
        else
        begin
          sync1_q[g] <= pins_raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  // link domain: serial shifter on the serial clock pin
  logic [31:0] shift_q;
  logic [31:0] shift_d;

  always_comb
  begin
    shift_d = {category_select_1_i, shift_q[31:1]};  // first bit ends at slot 0
  end

  always_ff @(posedge category_select_2_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      shift_q <= `CSS_WORD_RESET;
    end
    else
    begin
      shift_q <= shift_d;
    end
  end

  // pin decode, continuous from synchronised levels
  css_pkg::css_mode_t mode;
  css_pkg::css_load_t load;
  logic               disable_now;
  logic               latch_rise;
  logic               latch_last_q;
  logic [31:0]        par_word;
  logic [6:0]         cat_prefix;
  logic [7:0]         rate_code;
  logic [7:0]         acc_code;
  logic [7:0]         chnum_code;

  always_comb
  begin
    mode = (sync2_q[P_RA] && !sync2_q[P_RB]) ? css_pkg::CSS_SERIAL : css_pkg::CSS_PARALLEL;
    load = sync2_q[P_LEN] ? css_pkg::CSS_LOAD_32 : css_pkg::CSS_LOAD_192;
    disable_now = sync2_q[P_AA] && sync2_q[P_AB];
    if (mode == css_pkg::CSS_SERIAL)
    begin
      disable_now = sync2_q[P_AB];
    end
    latch_rise = sync2_q[P_C3] && !latch_last_q && (mode == css_pkg::CSS_SERIAL);
  end

  always_comb
  begin
    case ({sync2_q[P_C3], sync2_q[P_C2], sync2_q[P_C1]})
      3'h0:    cat_prefix = `CSS_CAT_GENERAL;
      3'h1:    cat_prefix = `CSS_CAT_MIXER;
      3'h2:    cat_prefix = `CSS_CAT_RATECONV;
      3'h3:    cat_prefix = `CSS_CAT_SAMPLER;
      3'h4:    cat_prefix = `CSS_CAT_ADC_FREE;
      3'h5:    cat_prefix = `CSS_CAT_ADC_PROT;
      3'h6:    cat_prefix = `CSS_CAT_SYNTH;
      default: cat_prefix = `CSS_CAT_MIC;
    endcase
    case ({sync2_q[P_RA], sync2_q[P_RB]})
      2'h1:    rate_code = `CSS_RATE_48K;
      2'h3:    rate_code = `CSS_RATE_32K;
      default: rate_code = `CSS_RATE_44K1;  // serial code never builds a parallel word
    endcase
    case ({sync2_q[P_AA], sync2_q[P_AB]})
      2'h1:    acc_code = `CSS_ACC_LEVEL3;
      2'h2:    acc_code = `CSS_ACC_LEVEL1;
      default: acc_code = `CSS_ACC_LEVEL2;  // both high disables, slots keep level two
    endcase
    chnum_code = (sync2_q[P_WCK] ^ !sync2_q[P_LRS]) ? `CSS_CHNUM_SECOND : `CSS_CHNUM_FIRST;
    if (sync2_q[P_M2])
    begin
      chnum_code = 8'h00;
    end
  end

  always_comb
  begin
    par_word = `CSS_WORD_RESET;  // slots 0, 1 and 4 stay zero
    par_word[`CSS_SLOT_COPY] = sync2_q[P_COPY];
    par_word[`CSS_SLOT_EMPHASIS_PIN] = sync2_q[P_EMPHASIS_PIN];
    par_word[`CSS_SLOT_CHMODE] = sync2_q[P_M2];
    par_word = par_word | place({cat_prefix, sync2_q[P_LEN] && (cat_prefix != `CSS_CAT_GENERAL)}, 8,
                                `CSS_SLOT_CAT);
    par_word = par_word | place(rate_code, 4, `CSS_SLOT_RATE) | place(acc_code, 2, `CSS_SLOT_ACC);
  end

  // frame position, group index, loading registers and outputs
  logic [7:0]  pos_q;
  logic [7:0]  pos_d;
  logic [2:0]  grp_q;
  logic [2:0]  grp_d;
  logic [31:0] holding_q;
  logic [31:0] holding_d;
  logic [31:0] setting_q;
  logic [31:0] setting_d;
  logic [31:0] group_word_q;
  logic [31:0] group_word_d;
  logic [31:0] status_d;
  logic        marker_fall;
  logic        group_start;
  logic        dout_a_d;
  logic        dout_b_d;

  always_comb
  begin
    pos_d = pos_q;
    grp_d = grp_q;
    holding_d = holding_q;
    setting_d = setting_q;
    group_word_d = group_word_q;
    group_start = frame_tick_i && (pos_q == GRP_LAST);
    marker_fall = frame_tick_i && (pos_q == GRP_HALF);
    if (frame_tick_i)
    begin
      pos_d = group_start ? 8'h00 : pos_q + 8'h01;
      if (group_start)
      begin
        grp_d = (grp_q == BLK_LAST) ? 3'h0 : grp_q + 3'h1;
      end
    end
    if (mode == css_pkg::CSS_PARALLEL)
    begin
      holding_d = `CSS_WORD_RESET;
      setting_d = `CSS_WORD_RESET;
      group_word_d = `CSS_WORD_RESET;
    end
    else
    begin
      // latch moves shifted bits; shifter is quiet around the latch pulse
      if (latch_rise)
      begin
        if (load == css_pkg::CSS_LOAD_32)
        begin
          setting_d = shift_q;
        end
        else
        begin
          holding_d = shift_q;
        end
      end
      if (marker_fall && load == css_pkg::CSS_LOAD_192)
      begin
        setting_d = holding_q;
      end
      if (group_start)
      begin
        if (load == css_pkg::CSS_LOAD_32)
        begin
          group_word_d = (grp_d == 3'h0) ? setting_q : `CSS_WORD_RESET;
        end
        else
        begin
          group_word_d = setting_q;
        end
      end
    end
  end

  // final word: live overrides on group zero
  always_comb
  begin
    status_d = group_word_q;
    if (mode == css_pkg::CSS_PARALLEL)
    begin
      status_d = (grp_q == 3'h0) ? par_word : `CSS_WORD_RESET;
    end
    else if (grp_q == 3'h0)
    begin
      status_d[`CSS_SLOT_EMPHASIS_PIN] = group_word_q[`CSS_SLOT_EMPHASIS_PIN] | sync2_q[P_EMPHASIS_PIN];
    end
    if (grp_q == 3'h0)
    begin
      status_d = (status_d & ~place(8'h0F, 4, `CSS_SLOT_CHNUM)) | place(chnum_code, 4, `CSS_SLOT_CHNUM);
    end
    dout_a_d = mod_data_a_i && !disable_now;
    dout_b_d = mod_data_b_i && !disable_now;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pos_q <= 8'h00;
      grp_q <= 3'h0;
      holding_q <= `CSS_WORD_RESET;
      setting_q <= `CSS_WORD_RESET;
      group_word_q <= `CSS_WORD_RESET;
      latch_last_q <= 1'b0;
      status_word_o <= `CSS_WORD_RESET;
      status_group_o <= 3'h0;
      block_start_o <= 1'b0;
      frame32_marker_o <= 1'b0;
      serial_mode_o <= 1'b0;
      output_disable_o <= 1'b0;
      digital_out_a_o <= 1'b0;
      digital_out_b_o <= 1'b0;
    end
    else
    begin
      pos_q <= pos_d;
      grp_q <= grp_d;
      holding_q <= holding_d;
      setting_q <= setting_d;
      group_word_q <= group_word_d;
      latch_last_q <= sync2_q[P_C3];
      status_word_o <= status_d;
      status_group_o <= grp_q;
      // high in frames 0 to 31
      block_start_o <= (grp_q == 3'h0);
      frame32_marker_o <= (pos_q <= GRP_HALF);
      serial_mode_o <= (mode == css_pkg::CSS_SERIAL);
      output_disable_o <= disable_now;
      digital_out_a_o <= dout_a_d;
      digital_out_b_o <= dout_b_d;
    end
  end

endmodule

//--- tb/css_serial_host.sv
// Purpose: microcontroller model loading channel status over the three-wire port
// Assumes: serial clock idles high; data line is pulled up and latch rests low when idle
// Notes:   the 15 ns serial clock runs only while a word is shifted
`timescale 1ns/1ps
module css_serial_host (
  output logic sdata_o,
  output logic sclk_o,
  output logic latch_o
);
  // idle levels before any load
  initial
  begin
    sdata_o = 1'b1;
    sclk_o  = 1'b1;
    latch_o = 1'b0;
  end

  // slot 0 goes first; latch only after the clock has gone quiet
  task automatic send(input logic [31:0] w);
    for (int i = 0; i < 32; i++)
    begin
      #7.5 sclk_o = 1'b0;
      sdata_o = w[i];
      #7.5 sclk_o = 1'b1;
    end
    #7.5 sdata_o = 1'b1; // released line rests at its pull-up level
    // latch far ahead of marker fall
    #100 latch_o = 1'b1;
    #200 latch_o = 1'b0;
  endtask
endmodule

//--- tb/css_channel_status_setup_asserts.sv
// Purpose: port-level checks for the channel status setup block
// Assumes: pin levels reach outputs three clock edges after they change
// Notes:   an up-counter masks the edges just after reset
`timescale 1ns/1ps
module css_channel_status_setup_asserts #(
  parameter int GROUPS_PER_BLOCK = 6
) (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        rate_select_a_i,
  input wire logic        rate_select_b_i,
  input wire logic        accuracy_select_a_i,
  input wire logic        accuracy_select_b_i,
  input wire logic        channel_mode_select_b_i,
  input wire logic        clock_polarity_select_i,
  input wire logic        word_clock_i,
  input wire logic        frame_tick_i,
  input wire logic        mod_data_a_i,
  input wire logic        mod_data_b_i,
  input wire logic        digital_out_a_o,
  input wire logic        digital_out_b_o,
  input wire logic        block_start_o,
  input wire logic        frame32_marker_o,
  input wire logic [31:0] status_word_o,
  input wire logic [2:0]  status_group_o,
  input wire logic        serial_mode_o,
  input wire logic        output_disable_o
);
  logic [2:0] up_q;
  logic [2:0] up_d;
  // history count; $past is meaningless until it saturates
  always_comb up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      up_q <= 3'h0;
    else
      up_q <= up_d;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_2ch;
    (!channel_mode_select_b_i && $stable(word_clock_i) && $stable(clock_polarity_select_i)) [*3];
  endsequence
  property p_mode;
    up_q == 3'h7 |-> serial_mode_o == ($past(rate_select_a_i, 3) && !$past(rate_select_b_i, 3));
  endproperty
  property p_dis;
    up_q == 3'h7 |-> output_disable_o == ($past(accuracy_select_b_i, 3) && ($past(accuracy_select_a_i, 3)
      || ($past(rate_select_a_i, 3) && !$past(rate_select_b_i, 3))));
  endproperty
  property p_low;
    output_disable_o [*2] |-> !digital_out_a_o && !digital_out_b_o;
  endproperty
  property p_follow;
    !output_disable_o [*3] |-> digital_out_a_o == $past(mod_data_a_i) && digital_out_b_o == $past(mod_data_b_i);
  endproperty
  property p_step;
    up_q == 3'h7 && $changed(status_group_o) |-> $past(frame_tick_i, 2) && status_group_o ==
      (($past(status_group_o) == GROUPS_PER_BLOCK - 1) ? 3'h0 : $past(status_group_o) + 3'h1);
  endproperty
  property p_marker;
    up_q == 3'h7 && $changed(frame32_marker_o) |-> $past(frame_tick_i, 2);
  endproperty
  property p_block;
    up_q == 3'h7 |-> block_start_o == (status_group_o == 3'h0);
  endproperty
  property p_ch4;
    block_start_o && $past(channel_mode_select_b_i, 3) && $past(channel_mode_select_b_i, 4)
      |-> status_word_o[23:20] == 4'h0;
  endproperty
  property p_ch2;
    s_2ch ##3 block_start_o |-> status_word_o[23:20] ==
      (($past(word_clock_i, 3) ^ $past(clock_polarity_select_i, 3)) ? 4'h1 : 4'h2);
  endproperty
  a_mode: assert property (p_mode) else $error("serial mode decode mismatch");
  a_dis: assert property (p_dis) else $error("output disable decode mismatch");
  a_low: assert property (p_low) else $error("outputs not held low");
  a_follow: assert property (p_follow) else $error("outputs do not follow data");
  a_step: assert property (p_step) else $error("group sequence wrong");
  a_marker: assert property (p_marker) else $error("marker moved without frame");
  a_block: assert property (p_block) else $error("block start not tied to group 0");
  a_ch4: assert property (p_ch4) else $error("channel number not zero");
  a_ch2: assert property (p_ch2) else $error("channel number code wrong");
  c_ser: cover property (serial_mode_o && output_disable_o);
  c_wrap: cover property (status_group_o == GROUPS_PER_BLOCK - 1 ##1 status_group_o == 3'h0);
  c_ch4: cover property (block_start_o && status_word_o[5]);
endmodule
bind css_channel_status_setup css_channel_status_setup_asserts #(.GROUPS_PER_BLOCK(GROUPS_PER_BLOCK)) u_css_asserts (.*);

//--- tb/css_channel_status_setup_bench.sv
// Purpose: self-checking bench for the channel status setup block
// Assumes: one frame tick every 80 clocks, eight frames a group
// Notes:   outputs are sampled on the falling clock edge
`timescale 1ns/1ps
module css_channel_status_setup_bench;
  localparam int GRP = 6;
  logic        clk_i = 1'b0, resetn_i = 1'b0, ra = 1'b0, rb = 1'b0, ka = 1'b0, kb = 1'b0;
  logic        ln = 1'b0, em = 1'b0, cp = 1'b0, m2 = 1'b0, pol = 1'b1, wc = 1'b0, tick = 1'b0;
  logic        mda = 1'b0, mdb = 1'b0, sd, sc, lt, do_a, do_b, blk, mk, smode, odis, ser;
  logic [2:0]  cat = 3'h0, grp;
  logic [6:0]  tcnt = 7'h00;
  logic [31:0] word;
  int          n_fail = 0, checks = 0;
  always #2 clk_i = ~clk_i;
  // frame pacing slow enough for a serial word inside half a group
  always @(posedge clk_i)
  begin
    tcnt <= (tcnt == 7'h4F) ? 7'h00 : tcnt + 7'h01;
    tick <= (tcnt == 7'h4F);
    mda  <= tcnt[0];
    mdb  <= ~tcnt[0];
  end
  assign ser = ra & ~rb; // category pins carry the serial port only here
  css_channel_status_setup #(.FRAMES_PER_GROUP(8), .GROUPS_PER_BLOCK(GRP)) u_css_channel_status_setup (
    .clk_i(clk_i), .resetn_i(resetn_i), .rate_select_a_i(ra), .rate_select_b_i(rb),
    .accuracy_select_a_i(ka), .accuracy_select_b_i(kb), .category_select_1_i(ser ? sd : cat[0]),
    .category_select_2_i(ser ? sc : cat[1]), .category_select_3_i(ser ? lt : cat[2]),
    .length_select_i(ln), .emphasis_pin_i(em), .copy_pin_i(cp), .channel_mode_select_b_i(m2),
    .clock_polarity_select_i(pol), .word_clock_i(wc), .frame_tick_i(tick), .mod_data_a_i(mda),
    .mod_data_b_i(mdb), .digital_out_a_o(do_a), .digital_out_b_o(do_b), .block_start_o(blk),
    .frame32_marker_o(mk), .status_word_o(word), .status_group_o(grp), .serial_mode_o(smode),
    .output_disable_o(odis));
  css_serial_host u_css_serial_host (.sdata_o(sd), .sclk_o(sc), .latch_o(lt));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic clks(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wait_grp(input logic [2:0] g);
    for (int k = 0; k < 9000 && grp !== g; k++)
      @(negedge clk_i);
    chk("group index", grp, g);
  endtask
  // group 0 word expected from the parallel pin levels
  function automatic logic [31:0] exp_par();
    logic [31:0] w;
    logic [6:0]  ct [8];
    ct = '{7'h00, 7'h24, 7'h2C, 7'h22, 7'h30, 7'h34, 7'h50, 7'h58};
    w = {2'h0, kb, ka, 2'h0, rb, ra & rb, m2 ? 4'h0 : ((wc ^ pol) ? 4'h1 : 4'h2), 4'h0,
         ln & (cat != 3'h0), 7'h00, 2'h0, m2, 1'b0, em, cp, 2'h0};
    w[14:8] = {<<{ct[cat]}};
    return w;
  endfunction
  task automatic t_mode();
    // codes pass through transiently; checks wait for settling
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      ra <= i[0];
      rb <= i[1];
      clks(6);
      chk("serial mode", smode, i == 1);
    end
    $display("test mode done");
  endtask
  task automatic t_disable();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      ra <= i[1];
      rb <= 1'b0;
      ka <= i[1] | i[0];
      kb <= i[1] ? i[0] : 1'b1;
      clks(7);
      chk("disable", odis, i[0]);
      chk("outputs", do_a | do_b, !i[0]);
    end
    $display("test disable done");
  endtask
  task automatic t_parallel();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      {cat, cp, em, ln, m2, pol, wc} <= {i[2:0], i[0], i[1], i[1], i == 5, i[2], i[0]};
      {ra, rb, ka, kb} <= {i % 3 == 2, i % 3 != 0, i % 3 == 2, i % 3 == 1};
      wait_grp(1);
      wait_grp(0);
      chk("parallel word", word, exp_par());
      chk("block start", blk, 1'b1);
    end
    $display("test parallel done");
  endtask
  task automatic t_serial();
    @(posedge clk_i);
    {ra, rb, ka, kb, em, ln, m2, pol, wc} <= 9'h05B;
    clks(6);
    @(posedge clk_i);
    ra <= 1'b1;
    wait_grp(1);
    wait_grp(0);
    chk("cleared", word, 32'h0020_0008);
    u_css_serial_host.send(32'hA5C3_0F12);
    clks(8);
    chk("not yet applied", word, 32'h0020_0008);
    wait_grp(1);
    wait_grp(0);
    chk("load 32", word, 32'hA523_0F1A);
    wait_grp(1);
    chk("group 1", word, 32'h0000_0000);
    @(posedge clk_i);
    ln <= 1'b0;
    wait_grp(2);
    for (int k = 0; k < 900 && mk !== 1'b0; k++)
      @(negedge clk_i);
    chk("marker low", mk, 1'b0);
    u_css_serial_host.send(32'h5A3C_96E1);
    wait_grp(4);
    chk("load 192", word, 32'h5A3C_96E1);
    $display("test serial done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    clks(8);
    t_mode();
    t_disable();
    t_parallel();
    t_serial();
    report_and_stop();
  end
  // watchdog well past the expected run length
  initial
  begin
    #380000;
    n_fail++;
    report_and_stop();
  end
endmodule
